// File: src/mch_top.v
// Control and status core of the memory card host controller
`timescale 1ns/1ps
`default_nettype none
`include "mch_regs.vh"

module mch_top #(
  parameter FW  = 6,
  parameter BLW = 12
) (
  // Clock and reset
  input  wire           clk_i,
  input  wire           rst_i,
  // Wishbone slave
  input  wire           wb_cyc_i,
  input  wire           wb_stb_i,
  input  wire           wb_we_i,
  input  wire [7:0]     wb_adr_i,
  input  wire [3:0]     wb_sel_i,
  input  wire [31:0]    wb_dat_i,
  output reg  [31:0]    wb_dat_o,
  output reg            wb_ack_o,
  // Card pins
  output wire           card_clock_pin_o,
  input  wire           card_data_line3_pin_i,
  input  wire           card_busy_pin_i,
  // Card engine events
  input  wire           eng_need_clk_i,
  input  wire           eng_cmd_end_i,
  input  wire           eng_resp_start_i,
  input  wire           eng_resp_end_i,
  input  wire           eng_resp_crc_err_i,
  input  wire           eng_rd_start_i,
  input  wire           eng_rd_crc_err_i,
  input  wire           eng_wr_crc_err_i,
  input  wire           eng_byte_moved_i,
  input  wire           eng_data_end_i,
  input  wire           eng_tx_shift_empty_i,
  input  wire           eng_rx_shift_full_i,
  // FIFO side
  input  wire [FW-1:0]  fifo_level_i,
  input  wire [31:0]    fifo_rx_data_i,
  // Command and DMA requests
  output reg            cmd_send_o,
  output reg  [15:0]    cmd_word_o,
  output reg  [BLW-1:0] blk_len_o,
  output reg            dma_req_o,
  output reg            card_clk_rise_o,
  output reg            irq_o
);

  // ----------------------------------------------------------------
  // Registers and wires
  // ----------------------------------------------------------------
  reg  [7:0]          div;
  reg                 clk_en;
  reg  [`MCH_NEV-1:0] imask;
  reg  [`MCH_NEV-1:0] evstat;
  reg  [7:0]          tmo_rs;
  reg  [15:0]         tmo_rd;
  reg  [15:0]         blk_cnt;
  reg  [15:0]         blk_rem;
  reg  [FW-1:0]       thr;
  reg  [1:0]          edge_sel;
  reg  [BLW-1:0]      byte_cnt;
  reg                 dma_armed;
  reg                 dma_run;
  reg                 all_moved;
  reg                 busy_wait;
  reg                 d3_m;
  reg                 d3_s;
  reg                 d3_d;
  reg                 bs_m;
  reg                 bs_s;
  reg                 rx_above_d;
  reg                 tx_below_d;
  reg  [`MCH_NEV-1:0] ev_set;
  reg  [31:0]         next_rdata;
  wire                req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire                wr       = req && wb_we_i;
  wire                rd       = req && !wb_we_i;
  wire [31:0]         wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire                wr_clk   = wr && (wb_adr_i == `MCH_A_CLKCTL);
  wire                wr_cmd   = wr && (wb_adr_i == `MCH_A_CMD);
  wire                wr_trg   = wr && (wb_adr_i == `MCH_A_DMATRG) &&
                                 wb_sel_i[0] && wb_dat_i[`MCH_DMA_TRIG];
  wire                rd_stat  = rd && (wb_adr_i == `MCH_A_EVSTAT);
  wire                rd_rx    = rd && (wb_adr_i == `MCH_A_RXDATA);
  wire                pin_q;
  wire                clk_rise;
  wire                clk_stop;
  wire                rs_busy;
  wire                rs_exp;
  wire                rd_busy;
  wire                rd_exp;
  wire                rx_above = (fifo_level_i > thr);
  wire                tx_below = (fifo_level_i < thr);
  wire                last_in_blk = (byte_cnt + {{(BLW-1){1'b0}}, 1'b1} == blk_len_o);
  wire                final_byte  = eng_byte_moved_i && last_in_blk &&
                                    (blk_cnt != 16'h0000) && (blk_rem == 16'h0001);
  wire                cmd_busy_exp = cmd_word_o[`MCH_CMD_BSY];
  wire                cmd_has_rsp  = cmd_word_o[`MCH_CMD_RSP];
  wire                cmd_rd_data  = cmd_word_o[`MCH_CMD_DAT] && !cmd_word_o[`MCH_CMD_WR];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      d3_m <= 1'b0;
      d3_s <= 1'b0;
      d3_d <= 1'b0;
      bs_m <= 1'b0;
      bs_s <= 1'b0;
    end else begin
      d3_m <= card_data_line3_pin_i;
      d3_s <= d3_m;
      d3_d <= d3_s;
      bs_m <= card_busy_pin_i;
      bs_s <= bs_m;
    end
  end

  // ----------------------------------------------------------------
  // Card clock and wait timers
  // ----------------------------------------------------------------
  // demand gated clock
  mch_clkdiv #(
    .DW (8)
  ) u_clkdiv (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .div_i     (div),
    .run_i     (clk_en || eng_need_clk_i || rs_busy || rd_busy || busy_wait),
    .pin_o     (pin_q),
    .rise_o    (clk_rise),
    .stopped_o (clk_stop)
  );

  assign card_clock_pin_o = pin_q;

  mch_tmo #(
    .W (8)
  ) u_tmo_rs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (eng_cmd_end_i && cmd_has_rsp),
    .stop_i   (eng_resp_start_i),
    .tick_i   (clk_rise),
    .limit_i  (tmo_rs),
    .busy_o   (rs_busy),
    .expire_o (rs_exp)
  );

  mch_tmo #(
    .W (16)
  ) u_tmo_rd (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (eng_cmd_end_i && cmd_rd_data),
    .stop_i   (eng_rd_start_i),
    .tick_i   (clk_rise),
    .limit_i  (tmo_rd),
    .busy_o   (rd_busy),
    .expire_o (rd_exp)
  );

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  always @* begin
    ev_set = {`MCH_NEV{1'b0}};
    ev_set[`MCH_S_RSPD]  = eng_resp_end_i || (eng_cmd_end_i && !cmd_has_rsp);
    ev_set[`MCH_S_BSYD]  = busy_wait && !bs_s;
    ev_set[`MCH_S_DATD]  = eng_data_end_i && (all_moved || blk_cnt == 16'h0000);
    ev_set[`MCH_S_TORS]  = rs_exp;
    ev_set[`MCH_S_TORD]  = rd_exp;
    ev_set[`MCH_S_RESPONSE_CRC_ERROR_FLAG] = eng_resp_crc_err_i;
    ev_set[`MCH_S_READ_CRC_ERROR_FLAG] = eng_rd_crc_err_i;
    ev_set[`MCH_S_WRITE_CRC_ERROR_FLAG] = eng_wr_crc_err_i;
    ev_set[`MCH_S_RXRDY] = rx_above && !rx_above_d;
    ev_set[`MCH_S_TXRDY] = tx_below && !tx_below_d;
    case (edge_sel)
      `MCH_EDGE_RISE: ev_set[`MCH_S_EDGE] = d3_s && !d3_d;
      `MCH_EDGE_FALL: ev_set[`MCH_S_EDGE] = !d3_s && d3_d;
      `MCH_EDGE_BOTH: ev_set[`MCH_S_EDGE] = d3_s ^ d3_d;
      default:        ev_set[`MCH_S_EDGE] = 1'b0;
    endcase
    ev_set[`MCH_S_LAST]  = final_byte;
  end

  // ----------------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------------
  // Set wins over a clear by status read in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      evstat     <= {`MCH_NEV{1'b0}};
      irq_o      <= 1'b0;
      rx_above_d <= 1'b0;
      tx_below_d <= 1'b0;
    end else begin
      rx_above_d <= rx_above;
      tx_below_d <= tx_below;
      if (rd_stat) begin
        evstat <= ev_set;
      end else begin
        evstat <= (evstat | ev_set) &
                  ~({{(`MCH_NEV-1){1'b0}}, rd_rx} << `MCH_S_RXRDY) | ev_set;
      end
      irq_o <= |(evstat & imask);
    end
  end

  // ----------------------------------------------------------------
  // Block bookkeeping
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      byte_cnt  <= {BLW{1'b0}};
      blk_rem   <= 16'h0000;
      all_moved <= 1'b0;
      busy_wait <= 1'b0;
    end else begin
      if (wr_cmd) begin
        byte_cnt  <= {BLW{1'b0}};
        blk_rem   <= blk_cnt;
        all_moved <= 1'b0;
      end else if (eng_byte_moved_i) begin
        if (last_in_blk) begin
          byte_cnt <= {BLW{1'b0}};
          if (blk_cnt != 16'h0000 && blk_rem != 16'h0000) begin
            blk_rem <= blk_rem - 16'h0001;
          end
        end else begin
          byte_cnt <= byte_cnt + {{(BLW-1){1'b0}}, 1'b1};
        end
        if (final_byte) begin
          all_moved <= 1'b1;
        end
      end
      if (ev_set[`MCH_S_RSPD] && cmd_busy_exp) begin
        busy_wait <= 1'b1;
      end else if (!bs_s || wr_cmd) begin
        busy_wait <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command issue and DMA requests
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmd_send_o      <= 1'b0;
      dma_req_o       <= 1'b0;
      dma_armed       <= 1'b0;
      dma_run         <= 1'b0;
      card_clk_rise_o <= 1'b0;
    end else begin
      card_clk_rise_o <= clk_rise;
      cmd_send_o      <= 1'b0;
      dma_req_o       <= 1'b0;
      if (wr_cmd) begin
        cmd_send_o <= 1'b1;
        dma_armed  <= wb_dat_i[`MCH_CMD_DAT] && wb_dat_i[`MCH_CMD_WR];
        dma_run    <= 1'b0;
      end else if (wr_trg) begin
        if (dma_armed) begin
          dma_req_o <= 1'b1;
          dma_armed <= 1'b0;
          dma_run   <= 1'b1;
        end else begin
          cmd_send_o <= 1'b1;
        end
      end else if (dma_run) begin
        dma_req_o <= ev_set[`MCH_S_TXRDY];
        if (all_moved) begin
          dma_run <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Bytes not enabled by sel keep their old value
  always @(posedge clk_i) begin
    if (rst_i) begin
      div        <= `MCH_RST_DIV;
      clk_en     <= 1'b0;
      imask      <= {`MCH_NEV{1'b0}};
      tmo_rs     <= `MCH_RST_TMORS;
      tmo_rd     <= `MCH_RST_TMORD;
      blk_len_o  <= `MCH_RST_BLKLEN;
      blk_cnt    <= `MCH_RST_BLKCNT;
      cmd_word_o <= 16'h0000;
      thr        <= `MCH_RST_THR;
      edge_sel   <= 2'h0;
    end else if (wr) begin
      case (wb_adr_i)
        `MCH_A_CLKCTL: begin
          if (wb_sel_i[0]) begin
            div <= wb_dat_i[`MCH_CLK_DIV_HI:0];
          end
          if (wb_sel_i[1]) begin
            clk_en <= wb_dat_i[`MCH_CLK_EN];
          end
        end
        `MCH_A_IMASK:   imask  <= (imask & ~wmask[`MCH_NEV-1:0]) |
                                  (wb_dat_i[`MCH_NEV-1:0] & wmask[`MCH_NEV-1:0]);
        `MCH_A_RSPTMO:  tmo_rs <= (tmo_rs & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
        `MCH_A_RDTMO:   tmo_rd <= (tmo_rd & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `MCH_A_BLKLEN:  blk_len_o <= (blk_len_o & ~wmask[BLW-1:0]) |
                                     (wb_dat_i[BLW-1:0] & wmask[BLW-1:0]);
        `MCH_A_BLKCNT:  blk_cnt <= (blk_cnt & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `MCH_A_CMD:     cmd_word_o <= (cmd_word_o & ~wmask[15:0]) |
                                      (wb_dat_i[15:0] & wmask[15:0]);
        `MCH_A_FIFOCTL: thr <= (thr & ~wmask[FW-1:0]) | (wb_dat_i[FW-1:0] & wmask[FW-1:0]);
        `MCH_A_LINECTL: edge_sel <= (edge_sel & ~wmask[1:0]) | (wb_dat_i[1:0] & wmask[1:0]);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Unmapped and write-only addresses read as zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `MCH_A_CLKCTL:  next_rdata = {23'h000000, clk_en, div};
      `MCH_A_IMASK:   next_rdata[`MCH_NEV-1:0] = imask;
      `MCH_A_RSPTMO:  next_rdata[7:0] = tmo_rs;
      `MCH_A_RDTMO:   next_rdata[15:0] = tmo_rd;
      `MCH_A_BLKLEN:  next_rdata[BLW-1:0] = blk_len_o;
      `MCH_A_BLKCNT:  next_rdata[15:0] = blk_cnt;
      `MCH_A_CMD:     next_rdata[15:0] = cmd_word_o;
      `MCH_A_EVSTAT:  next_rdata[`MCH_NEV-1:0] = evstat;
      `MCH_A_LNSTAT: begin
        next_rdata[`MCH_L_BUSY]   = bs_s;
        next_rdata[`MCH_L_DAT3]   = d3_s;
        next_rdata[`MCH_L_TXEMP]  = eng_tx_shift_empty_i;
        next_rdata[`MCH_L_RXFUL]  = eng_rx_shift_full_i;
        next_rdata[`MCH_L_CARD_CLOCK_STOPPED_STATUS] = clk_stop;
      end
      `MCH_A_BLKREM:  next_rdata[15:0] = blk_rem;
      `MCH_A_FIFOCTL: next_rdata[FW-1:0] = thr;
      `MCH_A_RXDATA:  next_rdata = fifo_rx_data_i;
      `MCH_A_LINECTL: next_rdata[1:0] = edge_sel;
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request; dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule // mch_top

`default_nettype wire

// File: src/mch_regs.vh
// Register map, field positions and reset values of the card host control block
`ifndef MCH_REGS_VH
`define MCH_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MCH_A_CLKCTL   8'h00
`define MCH_A_IMASK    8'h04
`define MCH_A_RSPTMO   8'h08
`define MCH_A_RDTMO    8'h0c
`define MCH_A_BLKLEN   8'h10
`define MCH_A_BLKCNT   8'h14
`define MCH_A_CMD      8'h18
`define MCH_A_DMATRG   8'h1c
`define MCH_A_EVSTAT   8'h20
`define MCH_A_LNSTAT   8'h24
`define MCH_A_BLKREM   8'h28
`define MCH_A_FIFOCTL  8'h2c
`define MCH_A_RXDATA   8'h30
`define MCH_A_LINECTL  8'h34

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCH_CLK_DIV_HI  7
`define MCH_CLK_EN      8
`define MCH_CMD_RSP     6
`define MCH_CMD_BSY     7
`define MCH_CMD_DAT     8
`define MCH_CMD_WR      9
`define MCH_DMA_TRIG    0
`define MCH_EDGE_RISE   2'h1
`define MCH_EDGE_FALL   2'h2
`define MCH_EDGE_BOTH   2'h3

// Event status bit positions, shared with the mask register
`define MCH_S_RSPD   0
`define MCH_S_BSYD   1
`define MCH_S_DATD   2
`define MCH_S_TORS   3
`define MCH_S_TORD   4
`define MCH_S_RESPONSE_CRC_ERROR_FLAG  5
`define MCH_S_READ_CRC_ERROR_FLAG  6
`define MCH_S_WRITE_CRC_ERROR_FLAG  7
`define MCH_S_RXRDY  8
`define MCH_S_TXRDY  9
`define MCH_S_EDGE   10
`define MCH_S_LAST   11
`define MCH_NEV      12

// Line status bit positions
`define MCH_L_BUSY   0
`define MCH_L_DAT3   1
`define MCH_L_TXEMP  2
`define MCH_L_RXFUL  3
`define MCH_L_CARD_CLOCK_STOPPED_STATUS 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MCH_RST_DIV    8'h00
`define MCH_RST_TMORS  8'h00
`define MCH_RST_TMORD  16'h0000
`define MCH_RST_BLKLEN 12'h200
`define MCH_RST_BLKCNT 16'h0000
`define MCH_RST_THR    6'h08

`endif

// File: src/mch_clkdiv.v
// Card clock divider with demand gating
`timescale 1ns/1ps
`default_nettype none

module mch_clkdiv #(
  parameter DW = 8
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // Control
  input  wire [DW-1:0] div_i,
  input  wire          run_i,
  // Card clock
  output reg           pin_o,
  output reg           rise_o,
  output reg           stopped_o
);

  reg  [DW-1:0] cnt;
  wire          wrap = (cnt == div_i);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // half period div+1
  // Stops only in the low phase so the card never sees a runt pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt       <= {DW{1'b0}};
      pin_o     <= 1'b0;
      rise_o    <= 1'b0;
      stopped_o <= 1'b1;
    end else begin
      rise_o <= 1'b0;
      if (!run_i && !pin_o) begin
        cnt       <= {DW{1'b0}};
        stopped_o <= 1'b1;
      end else if (wrap) begin
        cnt       <= {DW{1'b0}};
        pin_o     <= ~pin_o;
        rise_o    <= ~pin_o;
        stopped_o <= 1'b0;
      end else begin
        cnt       <= cnt + {{(DW-1){1'b0}}, 1'b1};
        stopped_o <= 1'b0;
      end
    end
  end

endmodule // mch_clkdiv

`default_nettype wire

// File: src/mch_tmo.v
// Wait time-out counter ticking on card clock rising edges
`timescale 1ns/1ps
`default_nettype none

module mch_tmo #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // Control
  input  wire         start_i,
  input  wire         stop_i,
  input  wire         tick_i,
  input  wire [W-1:0] limit_i,
  // Result
  output reg          busy_o,
  output reg          expire_o
);

  reg [W-1:0] cnt;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A zero limit never expires, so the wait is unbounded
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt      <= {W{1'b0}};
      busy_o   <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (stop_i) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        busy_o <= 1'b1;
        cnt    <= {W{1'b0}};
      end else if (busy_o && tick_i) begin
        if (limit_i != {W{1'b0}} && cnt + {{(W-1){1'b0}}, 1'b1} == limit_i) begin
          busy_o   <= 1'b0;
          expire_o <= 1'b1;
        end else begin
          cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // mch_tmo

`default_nettype wire

// File: dv/mch_props.sv
// Assertion checker for the card host control block
`timescale 1ns/1ps
`default_nettype none
module mch_props (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic        card_clock_pin_o, cmd_send_o, dma_req_o, card_clk_rise_o, irq_o,
  input wire logic [15:0] cmd_word_o
);
  logic [7:0]  div;
  logic [8:0]  hcnt;
  logic [11:0] mask;
  logic        armed;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr  = req & wb_we_i;
  wire trg = wr & (wb_adr_i == 8'h1c) & wb_dat_i[0];
  // ----------------------------------------
  // Shadow settings, taken with the request
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      div   <= 8'h00;
      hcnt  <= 9'h000;
      mask  <= 12'h000;
      armed <= 1'b0;
    end else begin
      hcnt <= card_clock_pin_o ? hcnt + 9'h001 : 9'h000;
      if (wr && wb_adr_i == 8'h00) div <= wb_dat_i[7:0];
      if (wr && wb_adr_i == 8'h04) mask <= wb_dat_i[11:0];
      if (wr && wb_adr_i == 8'h18) armed <= wb_dat_i[9:8] == 2'h3;
      if (wr && wb_adr_i == 8'h1c) armed <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE:
    assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  AST_CMD_SEND:
    assert property (wr && wb_adr_i == 8'h18 |=> cmd_send_o && cmd_word_o == $past(wb_dat_i[15:0]))
      else $error("command write did not send");
  AST_TRIG_RD0:
    assert property (req && !wb_we_i && wb_adr_i == 8'h1c |=> wb_dat_o == 32'h0)
      else $error("trigger read not zero");
  AST_CLK_RISE:
    assert property ($rose(card_clock_pin_o) |-> ##[0:1] card_clk_rise_o)
      else $error("card clock rise not flagged");
  AST_CLK_HALF:
    assert property ($fell(card_clock_pin_o) |-> hcnt == {1'b0, div} + 9'h001)
      else $error("card clock high phase wrong");
  AST_DMA_FIRST:
    assert property (trg && armed |=> dma_req_o && !cmd_send_o) else $error("no first dma");
  AST_RESEND:
    assert property (trg && !armed |=> cmd_send_o && !dma_req_o) else $error("no resend");
  AST_IRQ_OR:
    assert property (wb_ack_o && $past(req && !wb_we_i && wb_adr_i == 8'h20)
      && (wb_dat_o[11:0] & mask) != 12'h000 |-> irq_o) else $error("irq missing");
endmodule // mch_props
bind mch_top mch_props mch_props_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .card_clock_pin_o(card_clock_pin_o),
  .cmd_send_o(cmd_send_o), .dma_req_o(dma_req_o), .card_clk_rise_o(card_clk_rise_o),
  .irq_o(irq_o), .cmd_word_o(cmd_word_o));
`default_nettype wire

// File: dv/mch_card_model.sv
// Behavioural card: command frame and delayed response on card clock rises
`timescale 1ns/1ps
`default_nettype none
module mch_card_model #(
  parameter logic [7:0] CLEN = 8'h08
) (
  input  wire logic       clk_i, rst_i, cmd_send_i, clk_rise_i,
  input  wire logic [7:0] rsp_dly_i,
  output wire logic       need_clk_o,
  output var  logic       cmd_end_o, resp_start_o, resp_end_o
);
  logic [1:0] st;
  logic [7:0] cnt;
  // Clock needed for the whole frame and the wait; zero delay never answers
  assign need_clk_o = st != 2'd0;
  always @(posedge clk_i) begin
    cmd_end_o <= 1'b0;
    resp_start_o <= 1'b0;
    resp_end_o <= 1'b0;
    if (rst_i || cmd_send_i) begin
      st  <= rst_i ? 2'd0 : 2'd1;
      cnt <= CLEN;
    end else if (st != 2'd0 && clk_rise_i && !(st == 2'd2 && rsp_dly_i == 8'h00)) begin
      if (cnt != 8'h01) cnt <= cnt - 8'h01;
      else begin
        st <= st + 2'd1;
        cnt <= st == 2'd1 ? rsp_dly_i : 8'h04;
        cmd_end_o <= st == 2'd1;
        resp_start_o <= st == 2'd2;
        resp_end_o <= st == 2'd3;
      end
    end
  end
endmodule // mch_card_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking testbench for the card host control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, dat3 = 1'b0, bsy = 1'b0;
  logic [7:0]  adr = 8'h00, rsp_dly = 8'h00, ev = 8'h00;
  logic [5:0]  lvl = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, rxd = 32'ha5a50f0f;
  wire  [31:0] dat_o;
  wire  [11:0] blen;
  wire         ack, cpin, csend, dreq, crise, irq, need, cend, rs, re;
  int          n_errors = 0, total_checks = 0, cyc_cnt = 0;
  always #4 clk_i = ~clk_i;
  mch_top mch_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .card_clock_pin_o(cpin), .card_data_line3_pin_i(dat3),
    .card_busy_pin_i(bsy), .eng_need_clk_i(need), .eng_cmd_end_i(cend),
    .eng_resp_start_i(rs), .eng_resp_end_i(re), .eng_resp_crc_err_i(ev[0]),
    .eng_rd_start_i(ev[7]), .eng_rd_crc_err_i(ev[1]), .eng_wr_crc_err_i(ev[2]),
    .eng_byte_moved_i(ev[3]), .eng_data_end_i(ev[4]), .eng_tx_shift_empty_i(ev[5]),
    .eng_rx_shift_full_i(ev[6]), .fifo_level_i(lvl), .fifo_rx_data_i(rxd),
    .cmd_send_o(csend), .cmd_word_o(), .blk_len_o(blen), .dma_req_o(dreq),
    .card_clk_rise_o(crise), .irq_o(irq));
  mch_card_model mch_card_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd_send_i(csend),
    .clk_rise_i(crise), .rsp_dly_i(rsp_dly), .need_clk_o(need), .cmd_end_o(cend),
    .resp_start_o(rs), .resp_end_o(re));
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i) ev <= v;
    @(posedge clk_i) ev <= 8'h00;
    repeat (3) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h10, 32'h200);
    rd(8'h3c, 32'h0);
    rd(8'h1c, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    rd(8'h24, 32'h10);
    bus(1'b1, 8'h10, 32'h200);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h04, 32'hfff);
    bus(1'b1, 8'h08, 32'h4);
    bus(1'b1, 8'h18, 32'h40);
    repeat (120) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    rd(8'h20, 32'h8);
    rd(8'h24, 32'h0);
    rsp_dly <= 8'h03;
    bus(1'b1, 8'h08, 32'h5);
    bus(1'b1, 8'h18, 32'h40);
    repeat (120) @(posedge clk_i);
    rd(8'h20, 32'h1);
    rsp_dly <= 8'h00;
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h0c, 32'h3);
    bus(1'b1, 8'h18, 32'h140);
    repeat (150) @(posedge clk_i);
    rd(8'h20, 32'h10);
    $display("timing tests done");
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h18, 32'h0);
    repeat (80) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rd(8'h20, 32'h1);
    bus(1'b1, 8'h18, 32'h300);
    bus(1'b1, 8'h1c, 32'h1);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h1c, 32'h1);
    repeat (80) @(posedge clk_i);
    bus(1'b0, 8'h20, 32'h0);
    for (int i = 0; i < 3; i++) begin
      pulse(8'h01 << i);
      rd(8'h20, 32'h20 << i);
    end
    $display("command tests done");
    ev <= 8'h60;
    bus(1'b1, 8'h34, 32'h1);
    dat3 <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(8'h24, 32'he);
    rd(8'h20, 32'h400);
    ev <= 8'h00;
    bus(1'b1, 8'h2c, 32'h8);
    lvl <= 6'd12;
    rd(8'h30, rxd);
    rd(8'h20, 32'h0);
    lvl <= 6'd4;
    rd(8'h20, 32'h200);
    bus(1'b1, 8'h0c, 32'h0);
    bus(1'b1, 8'h10, 32'h1);
    chk({20'h0, blen}, 32'h1);
    bus(1'b1, 8'h14, 32'h2);
    bus(1'b1, 8'h18, 32'h100);
    repeat (80) @(posedge clk_i);
    bus(1'b0, 8'h20, 32'h0);
    pulse(8'h08);
    rd(8'h28, 32'h1);
    pulse(8'h08);
    rd(8'h20, 32'h800);
    pulse(8'h10);
    rd(8'h20, 32'h4);
    $display("status tests done");
    bus(1'b1, 8'h34, 32'h2);
    dat3 <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h20, 32'h400);
    bsy <= 1'b1;
    rsp_dly <= 8'h03;
    bus(1'b1, 8'h18, 32'hc0);
    repeat (120) @(posedge clk_i);
    rd(8'h24, 32'h1);
    rd(8'h20, 32'h1);
    bsy <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h20, 32'h2);
    $display("line tests done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
